// file: evd_pkg.sv
// package: vector indices, cause bit positions and dispatch constants
package evd_pkg;
  localparam int VEC_W = 8;
  localparam int ADDR_W = 32;
  // vector table indices
  localparam logic [7:0] MACHINE_CHECK_VECTOR = 8'h04;
  localparam logic [7:0] KERNEL_STACK_INVALID_VECTOR = 8'h08;
  localparam logic [7:0] POWER_FAIL_VECTOR = 8'h0C;
  localparam logic [7:0] RESPRIV_VECTOR = 8'h10;
  localparam logic [7:0] EXTFUNC_VECTOR = 8'h14;
  localparam logic [7:0] RESOPND_VECTOR = 8'h18;
  localparam logic [7:0] RESADDR_VECTOR = 8'h1C;
  localparam logic [7:0] ACCVIO_VECTOR = 8'h20;
  localparam logic [7:0] XLATE_INVALID_VECTOR = 8'h24;
  localparam logic [7:0] TRACE_VECTOR = 8'h28;
  localparam logic [7:0] BREAKPOINT_VECTOR = 8'h2C;
  localparam logic [7:0] ARITH_VECTOR = 8'h34;
  localparam logic [7:0] CHMODE_BASE_VECTOR = 8'h40;
  localparam logic [7:0] SOFT_ERROR_VECTOR = 8'h54;
  localparam logic [7:0] HARD_ERROR_VECTOR = 8'h60;
  localparam logic [7:0] EMULATION_TRAP_VECTOR = 8'hC8;
  localparam logic [7:0] EMULATION_RESUME_VECTOR = 8'hCC;
  // machine check cause bits
  localparam int MC_MMGT = 0;
  localparam int MC_UCODE = 1;
  localparam int MC_STALL = 2;
  localparam int MC_XBUF_PAR = 3;
  localparam int MC_ICACHE_PAR = 4;
  localparam int MC_L2_UNCORR_RD = 5;
  localparam int MC_MEM_RD = 6;
  localparam int MC_N = 7;
  // soft error cause bits
  localparam int SE_ICACHE_PAR = 0;
  localparam int SE_L1_PAR = 1;
  localparam int SE_L2_UNCORR_TAG = 2;
  localparam int SE_L2_UNCORR_RD = 3;
  localparam int SE_L2_UNCORR_WB = 4;
  localparam int SE_L2_CORR = 5;
  localparam int SE_MEM_RD = 6;
  localparam int SE_BUS_PAR = 7;
  localparam int SE_N = 8;
  // hard error cause bits
  localparam int HE_L2_UNCORR_WR = 0;
  localparam int HE_NOACK_WR = 1;
  localparam int HE_FILL_OWN = 2;
  localparam int HE_N = 3;
  // architectural exception codes
  localparam int EX_RESPRIV = 0;
  localparam int EX_EXTFUNC = 1;
  localparam int EX_RESOPND = 2;
  localparam int EX_RESADDR = 3;
  localparam int EX_ACCVIO = 4;
  localparam int EX_XLATE = 5;
  localparam int EX_TRACE = 6;
  localparam int EX_BPT = 7;
  localparam int EX_ARITH = 8;
  localparam int EX_N = 9;
  // console halt cause bits
  localparam int HC_ISTK = 0;
  localparam int HC_KHALT = 1;
  localparam int HC_DOUBLE = 2;
  localparam int HC_BADVEC = 3;
  localparam int HC_NODE = 4;
  localparam int HC_SYSRST = 5;
  localparam int HC_N = 6;
  // reset values
  localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
  localparam logic [7:0] RESET_VEC = 8'h00;
  // dispatch kinds
  typedef enum logic [2:0] {
    EVD_NONE, EVD_HALT, EVD_MCHK, EVD_KSNV, EVD_PWR, EVD_HARD,
    EVD_SOFT, EVD_TRAP
  } evd_kind_t;
endpackage

// file: evd_sync.sv
// two-flop synchroniser for a group of asynchronous lines
`timescale 1ns/1ps
module evd_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r; // first stage, read only by q

  // two stages, cleared on reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// file: evd_dispatch.sv
// error and exception classifier with vector dispatch
`timescale 1ns/1ps
module evd_dispatch
  import evd_pkg::*;
#(
  parameter logic [31:0] HALT_ENTRY = 32'h2004_0000 // fixed console entry
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [31:0] VECTOR_TABLE_BASE,
  input wire logic [MC_N-1:0] MCHK_CAUSE,
  input wire logic KSTK_PUSH_FAULT,
  input wire logic POWER_FAIL_N,
  input wire logic [SE_N-1:0] SOFT_CAUSE,
  input wire logic SOFT_ERROR_N,
  input wire logic [HE_N-1:0] HARD_CAUSE,
  input wire logic HARD_ERROR_N,
  input wire logic [HC_N-1:0] HALT_CAUSE,
  input wire logic POWER_UP,
  input wire logic HALT_N,
  input wire logic EXC_VALID,
  input wire logic [3:0] EXC_CODE,
  input wire logic CHM_VALID,
  input wire logic [1:0] CHM_MODE,
  input wire logic EMUL_VALID,
  input wire logic FIRST_PART_DONE,
  input wire logic DISPATCH_ACK,
  output logic DISPATCH_VALID,
  output logic [2:0] DISPATCH_KIND,
  output logic [7:0] DISPATCH_VECTOR,
  output logic [31:0] DISPATCH_ADDR,
  output logic CONSOLE_HALT,
  output logic SOFT_PENDING,
  output logic HARD_PENDING
);
  logic [3:0] pin_s; // synchronised active-high pin levels
  logic pwr_s; // power fail level
  logic serr_s; // external soft error level
  logic herr_s; // external hard error level
  logic halt_s; // external halt level
  logic soft_r; // sticky soft error request
  logic hard_r; // sticky hard error request
  logic pwr_seen_r; // power fail already reported
  logic pwr_prev_r; // previous power fail level
  logic soft_set; // soft request this cycle
  logic hard_set; // hard request this cycle
  logic halt_req; // any halt cause
  logic busy; // a dispatch awaits its ack
  evd_kind_t kind_nxt; // winning kind
  logic [7:0] vec_nxt; // winning index

  // external lines are asynchronous: two flops first
  evd_sync #(.W(4)) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .d({~HALT_N, ~HARD_ERROR_N, ~SOFT_ERROR_N, ~POWER_FAIL_N}),
    .q(pin_s)
  );
  assign pwr_s = pin_s[0];
  assign serr_s = pin_s[1];
  assign herr_s = pin_s[2];
  assign halt_s = pin_s[3];

  // fixed index for an architectural exception code
  function automatic logic [7:0] exc_vec(input logic [3:0] code);
    unique case (code)
      4'(EX_RESPRIV): exc_vec = RESPRIV_VECTOR;
      4'(EX_EXTFUNC): exc_vec = EXTFUNC_VECTOR;
      4'(EX_RESOPND): exc_vec = RESOPND_VECTOR;
      4'(EX_RESADDR): exc_vec = RESADDR_VECTOR;
      4'(EX_ACCVIO): exc_vec = ACCVIO_VECTOR;
      4'(EX_XLATE): exc_vec = XLATE_INVALID_VECTOR;
      4'(EX_TRACE): exc_vec = TRACE_VECTOR;
      4'(EX_BPT): exc_vec = BREAKPOINT_VECTOR;
      4'(EX_ARITH): exc_vec = ARITH_VECTOR;
      default: exc_vec = RESPRIV_VECTOR; // illegal code: reserved instr
    endcase
  endfunction

  // nonfatal sources only feed the soft request
  assign soft_set = (|SOFT_CAUSE) | serr_s;
  // write, fill and external hard sources
  assign hard_set = (|HARD_CAUSE) | herr_s;
  // any halt cause, including power-up and halt line
  assign halt_req = (|HALT_CAUSE) | POWER_UP | halt_s;
  assign busy = DISPATCH_VALID & ~DISPATCH_ACK;

  // sticky interrupt requests; a new event wins over its clear
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      soft_r <= 1'b0;
      hard_r <= 1'b0;
    end else begin
      // latched whenever raised, independent of execution
      if (hard_set) begin
        hard_r <= 1'b1;
      end else if (!busy && kind_nxt == EVD_HARD) begin
        hard_r <= 1'b0;
      end
      // cache read error kept here even if a check also fires
      if (soft_set) begin
        soft_r <= 1'b1;
      end else if (!busy && kind_nxt == EVD_SOFT) begin
        soft_r <= 1'b0;
      end
    end
  end

  // power fail reported once per assertion of the line
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pwr_prev_r <= 1'b0;
      pwr_seen_r <= 1'b0;
    end else begin
      pwr_prev_r <= pwr_s;
      if (pwr_s && !pwr_prev_r) begin
        // new assertion; marked at once if offered in this same cycle,
        // else the acceptance edge would offer it a second time
        pwr_seen_r <= !busy && kind_nxt == EVD_PWR;
      end else if (!busy && kind_nxt == EVD_PWR) begin
        pwr_seen_r <= 1'b1;
      end
    end
  end

  // priority select: halt, stack, check, power, hard, soft, trap
  always_comb begin
    kind_nxt = EVD_NONE;
    vec_nxt = RESET_VEC;
    if (halt_req) begin
      kind_nxt = EVD_HALT; // no vector used
    end else if (KSTK_PUSH_FAULT) begin
      kind_nxt = EVD_KSNV;
      vec_nxt = KERNEL_STACK_INVALID_VECTOR;
    end else if (|MCHK_CAUSE) begin
      kind_nxt = EVD_MCHK; // any listed cause
      vec_nxt = MACHINE_CHECK_VECTOR; // tied to current instr
    end else if (pwr_s && !pwr_seen_r) begin
      kind_nxt = EVD_PWR;
      vec_nxt = POWER_FAIL_VECTOR;
    end else if (hard_r) begin
      kind_nxt = EVD_HARD;
      vec_nxt = HARD_ERROR_VECTOR;
    end else if (soft_r) begin
      kind_nxt = EVD_SOFT;
      vec_nxt = SOFT_ERROR_VECTOR;
    end else if (EXC_VALID) begin
      kind_nxt = EVD_TRAP;
      vec_nxt = exc_vec(EXC_CODE);
    end else if (CHM_VALID) begin
      kind_nxt = EVD_TRAP;
      vec_nxt = CHMODE_BASE_VECTOR + {4'h0, CHM_MODE, 2'b00};
    end else if (EMUL_VALID) begin
      kind_nxt = EVD_TRAP;
      vec_nxt = FIRST_PART_DONE ? EMULATION_RESUME_VECTOR
                                : EMULATION_TRAP_VECTOR;
    end
  end

  // dispatch output held until acknowledged
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      DISPATCH_VALID <= 1'b0;
      DISPATCH_KIND <= EVD_NONE;
      DISPATCH_VECTOR <= RESET_VEC;
      DISPATCH_ADDR <= RESET_ADDR;
    end else if (!busy) begin
      DISPATCH_VALID <= (kind_nxt != EVD_NONE);
      DISPATCH_KIND <= kind_nxt;
      DISPATCH_VECTOR <= vec_nxt;
      if (kind_nxt == EVD_HALT) begin
        DISPATCH_ADDR <= HALT_ENTRY; // fixed I/O-space entry
      end else begin
        DISPATCH_ADDR <= VECTOR_TABLE_BASE + {24'h0, vec_nxt};
      end
    end
  end

  // console halt level while a halt dispatch is offered
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      CONSOLE_HALT <= 1'b0;
    end else if (!busy) begin
      CONSOLE_HALT <= (kind_nxt == EVD_HALT);
    end
  end

  // pending views of the sticky requests
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      SOFT_PENDING <= 1'b0;
      HARD_PENDING <= 1'b0;
    end else begin
      SOFT_PENDING <= soft_r;
      HARD_PENDING <= hard_r;
    end
  end
endmodule

// file: evd_dispatch_sva.sv
// checker: dispatch outputs against their causes
`timescale 1ns/1ps
module evd_dispatch_sva
  import evd_pkg::*;
#(
  parameter logic [31:0] HALT_ENTRY = 32'h2004_0000 // arbitrary entry
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [31:0] VECTOR_TABLE_BASE,
  input wire logic [MC_N-1:0] MCHK_CAUSE,
  input wire logic KSTK_PUSH_FAULT,
  input wire logic [HC_N-1:0] HALT_CAUSE,
  input wire logic POWER_UP,
  input wire logic HALT_N,
  input wire logic DISPATCH_ACK,
  input wire logic DISPATCH_VALID,
  input wire logic [2:0] DISPATCH_KIND,
  input wire logic [7:0] DISPATCH_VECTOR,
  input wire logic [31:0] DISPATCH_ADDR,
  input wire logic CONSOLE_HALT
);
  // one clock domain, reset disables all checks
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  AST_HALT_ENTRY:
    assert property (DISPATCH_VALID && DISPATCH_KIND == EVD_HALT |->
      CONSOLE_HALT && DISPATCH_ADDR == HALT_ENTRY)
    else $error("halt not sent to fixed entry");
  AST_HALT_FLAG:
    assert property (CONSOLE_HALT |-> DISPATCH_VALID &&
      DISPATCH_KIND == EVD_HALT)
    else $error("halt flag without halt dispatch");
  AST_ADDR_SUM:
    assert property (DISPATCH_VALID && DISPATCH_KIND != EVD_HALT &&
      !($past(DISPATCH_VALID) && !$past(DISPATCH_ACK)) |->
      DISPATCH_ADDR == $past(VECTOR_TABLE_BASE) + 32'(DISPATCH_VECTOR))
    else $error("address is not base plus index");
  AST_HOLD:
    assert property (DISPATCH_VALID && !DISPATCH_ACK |=> DISPATCH_VALID
      && $stable(DISPATCH_VECTOR) && $stable(DISPATCH_ADDR))
    else $error("dispatch changed before acceptance");
  AST_MCHK_VEC:
    assert property (DISPATCH_VALID && DISPATCH_KIND == EVD_MCHK |->
      DISPATCH_VECTOR == 8'h04)
    else $error("check dispatch has wrong index");
  AST_SOFT_VEC:
    assert property (DISPATCH_VALID && DISPATCH_KIND == EVD_SOFT |->
      DISPATCH_VECTOR == 8'h54)
    else $error("soft dispatch has wrong index");
  AST_KSNV_VEC:
    assert property (DISPATCH_VALID && DISPATCH_KIND == EVD_KSNV |->
      DISPATCH_VECTOR == 8'h08)
    else $error("stack dispatch has wrong index");
  AST_PWR_VEC:
    assert property (DISPATCH_VALID && DISPATCH_KIND == EVD_PWR |->
      DISPATCH_VECTOR == 8'h0C)
    else $error("power dispatch has wrong index");
  AST_HARD_VEC:
    assert property (DISPATCH_VALID && DISPATCH_KIND == EVD_HARD |->
      DISPATCH_VECTOR == 8'h60)
    else $error("hard dispatch has wrong index");
  AST_EMUL_KIND:
    assert property (DISPATCH_VALID && DISPATCH_VECTOR inside {8'hC8,
      8'hCC} |-> DISPATCH_KIND == EVD_TRAP)
    else $error("emulation index on non-trap");
  AST_MCHK_TAKE:
    assert property (!DISPATCH_VALID && MCHK_CAUSE != '0 &&
      !KSTK_PUSH_FAULT && HALT_CAUSE == '0 && !POWER_UP &&
      $past(HALT_N, 2) |=>
      DISPATCH_VALID && DISPATCH_KIND == EVD_MCHK)
    else $error("check cause not dispatched");
endmodule
bind evd_dispatch evd_dispatch_sva #(.HALT_ENTRY(HALT_ENTRY))
  i_evd_dispatch_sva (.*);

// file: evd_consumer.sv
// partner model: service side accepting each dispatch after a lag
`timescale 1ns/1ps
module evd_consumer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic valid,
  input wire logic [3:0] lag,
  output logic ack
);
  logic [3:0] wait_r; // cycles the dispatch has waited
  // one-cycle accept once the lag has run out
  always_ff @(posedge clk) begin
    if (!nrst || ack || !valid) begin
      ack <= 1'b0;
      wait_r <= 4'h0;
    end else begin
      ack <= (wait_r >= lag);
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// file: error_vector_dispatch_test.sv
// testbench: drives causes, checks dispatched index and address
`timescale 1ns/1ps
module error_vector_dispatch_test import evd_pkg::*;;
  localparam logic [31:0] HE = 32'h2004_0000; // arbitrary entry
  localparam logic [7:0] EXV [10] = '{8'h10, 8'h14, 8'h18, 8'h1C,
    8'h20, 8'h24, 8'h28, 8'h2C, 8'h34, 8'h10};
  logic clk, nrst, kstk, pf_n, se_n, he_n, pup, h_n, exv, chv, emv;
  logic fpd, ack, vld, chlt, spend, hpend;
  logic [31:0] base, addr;
  logic [MC_N-1:0] mc;
  logic [SE_N-1:0] sc;
  logic [HE_N-1:0] hc;
  logic [HC_N-1:0] hlc;
  logic [3:0] exc, lag;
  logic [1:0] chm;
  logic [2:0] kind;
  logic [7:0] vec;
  int mismatches, num_checks, cycles;
  evd_dispatch #(.HALT_ENTRY(HE)) i_evd_dispatch (.CLK(clk),
    .NRST(nrst), .VECTOR_TABLE_BASE(base), .MCHK_CAUSE(mc),
    .KSTK_PUSH_FAULT(kstk), .POWER_FAIL_N(pf_n), .SOFT_CAUSE(sc),
    .SOFT_ERROR_N(se_n), .HARD_CAUSE(hc), .HARD_ERROR_N(he_n),
    .HALT_CAUSE(hlc), .POWER_UP(pup), .HALT_N(h_n), .EXC_VALID(exv),
    .EXC_CODE(exc), .CHM_VALID(chv), .CHM_MODE(chm), .EMUL_VALID(emv),
    .FIRST_PART_DONE(fpd), .DISPATCH_ACK(ack), .DISPATCH_VALID(vld),
    .DISPATCH_KIND(kind), .DISPATCH_VECTOR(vec), .DISPATCH_ADDR(addr),
    .CONSOLE_HALT(chlt), .SOFT_PENDING(spend), .HARD_PENDING(hpend));
  evd_consumer i_evd_consumer (.clk(clk), .nrst(nrst), .valid(vld),
    .lag(lag), .ack(ack));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // n edges, then settle past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // wait for a dispatch and judge it
  task automatic take(input logic [2:0] k, input logic [7:0] v);
    for (int n = 0; n < 20 && vld !== 1'b1; n++) tick(1);
    check(32'(kind), 32'(k));
    check(32'(vec), 32'(v));
    check(addr, k == EVD_HALT ? HE : base + 32'(v));
    check(32'(chlt), 32'(k == EVD_HALT));
  endtask
  // wait for the accepting edge
  task automatic ackw();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    #2;
  endtask
  // all exception codes, mode changes and emulation traps
  task automatic t_traps();
    for (int i = 0; i < 16; i++) begin
      exv = i < 10;
      chv = i inside {[10:13]};
      emv = i > 13;
      exc = 4'(i);
      chm = 2'(i - 10);
      fpd = i[0];
      if (i < 10) take(EVD_TRAP, EXV[i]);
      else if (i < 14) take(EVD_TRAP, 8'(i * 4 + 24));
      else take(EVD_TRAP, i[0] ? 8'hCC : 8'hC8);
      {exv, chv, emv} = 3'h0;
      ackw();
    end
  endtask
  // every check, soft, hard and halt cause alone
  task automatic t_causes();
    for (int i = 0; i < 25; i++) begin
      mc = i < 7 ? MC_N'(1 << i) : '0;
      sc = SE_N'(1 << (i - 7));
      hc = HE_N'(1 << (i - 15));
      hlc = HC_N'(1 << (i - 18));
      pup = i == 24;
      if (i > 6 && i < 18) tick(1);
      {sc, hc} = '0;
      if (i < 7) take(EVD_MCHK, 8'h04);
      else if (i < 15) take(EVD_SOFT, 8'h54);
      else if (i < 18) take(EVD_HARD, 8'h60);
      else take(EVD_HALT, 8'h00);
      {mc, hlc, pup} = '0;
      ackw();
    end
  endtask
  // pins, with a slow acceptor; power fail only once per assertion
  task automatic t_pins();
    lag = 4'h3;
    pf_n = 1'b0;
    take(EVD_PWR, 8'h0C);
    ackw();
    tick(4);
    check(32'(vld), 32'h0);
    pf_n = 1'b1;
    se_n = 1'b0;
    tick(1);
    se_n = 1'b1;
    take(EVD_SOFT, 8'h54);
    check(32'(spend), 32'h1);
    ackw();
    he_n = 1'b0;
    tick(1);
    he_n = 1'b1;
    take(EVD_HARD, 8'h60);
    check(32'(hpend), 32'h1);
    ackw();
    check(32'({spend, hpend}), 32'h0);
    h_n = 1'b0;
    take(EVD_HALT, 8'h00);
    h_n = 1'b1;
    ackw();
    lag = 4'h0;
  endtask
  // double reports, priorities and a wrapping base
  task automatic t_mix();
    base = 32'hFFFF_FFF8;
    mc[MC_L2_UNCORR_RD] = 1'b1;
    sc[SE_L2_UNCORR_RD] = 1'b1;
    tick(1);
    sc = '0;
    take(EVD_MCHK, 8'h04);
    mc = '0;
    ackw();
    take(EVD_SOFT, 8'h54);
    check(32'(spend), 32'h1);
    ackw();
    {kstk, mc[MC_MMGT], exv, exc} = {3'h7, 4'(EX_BPT)};
    hlc[HC_DOUBLE] = 1'b1;
    take(EVD_HALT, 8'h00);
    hlc = '0;
    ackw();
    take(EVD_KSNV, 8'h08);
    {kstk, mc} = '0;
    ackw();
    take(EVD_TRAP, 8'h2C);
    exv = 1'b0;
    ackw();
  endtask
  // print the verdict and stop
  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    {nrst, kstk, pup, exv, chv, emv, fpd} = '0;
    {pf_n, se_n, he_n, h_n} = 4'hF;
    {mc, sc, hc, hlc, exc, chm, lag} = '0;
    base = 32'h8000_1200;
    tick(3);
    nrst = 1'b1;
    check(32'(vld), 32'h0);
    tick(3);
    t_traps();
    t_causes();
    t_pins();
    t_mix();
    finish_test();
  end
endmodule
